// file: core/nvpsc_serial_port.sv
// serial command port and wiper control of a nonvolatile potentiometer
`timescale 1ns/1ps

// Overview of operation
// - Shift register locked for the whole nonvolatile store write time.
// - Ready output shows a completed nonvolatile save.
// - Held increment, decrement or shift repeats on every empty strobe.
// - Data field of a word loads the addressed wiper directly.
// - Command copies nonvolatile store content into the wiper.
// - At power-on each wiper loads from its store location.
// - Store holds midscale until the user saves a value.
// - Preset low forces midscale; its rising edge reloads from store.
// - Write protect low rejects all commands except 1 and 9.
// - Word is exactly WORD_BITS (16) bits, shifted most significant bit first.
// - Command field selects operation, address field target, data value.
// - Layout: command, address, padding, then data in low bits.
// - Serial output never pulls low while chip select is high.
// - Slave works in clock modes 0,0 and 1,1.
// - Serial and ready outputs are open drain, pulling low only.
// - Preset and write protect inputs are active low.
// - Increment, decrement and left or right shift per wiper.
// - One command refreshes all wipers from their store locations.
// - Every wiper and store location writable and readable serially.
// - Save wipers to store; extra user store bytes by address.
// - One input bit shifted in per rising serial clock edge.
// - Operation executes when chip select returns high.
// - Output repeats input delayed 16 clocks, except after readback.
// - Ready marks completion of commands 2, 3, 8, 9 and 10.
module nvpsc_serial_port
  import nvpsc_pkg::*;
#(
  parameter int WORD_BITS      = DEF_WORD_BITS,
  parameter int DATA_BITS      = DEF_DATA_BITS,
  parameter int WIPERS         = DEF_WIPERS,
  parameter int STORE_DEPTH    = DEF_STORE_DEPTH,
  parameter int NV_WRITE_COUNT = NV_WRITE_CYCLES
) (
  // system clock and reset
  input  wire logic                                clk_in,
  input  wire logic                                reset_n_in,
  // serial link
  input  wire logic                                sclk_in,
  input  wire logic                                cs_n_in,
  input  wire logic                                sdi_in,
  output logic                                     sdo_out,
  output logic                                     sdo_oe_out,
  // ready, open drain
  output logic                                     ready_out,
  output logic                                     ready_oe_out,
  // hardware controls
  input  wire logic                                preset_reload_n_in,
  input  wire logic                                write_protect_n_in,
  // wiper settings
  output logic [WIPERS-1:0][DATA_BITS-1:0]         wiper_setting_out,
  output logic                                     busy_out
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  localparam int HDR_BITS = CMD_BITS + ADDR_BITS;
  if (WORD_BITS < HDR_BITS + DATA_BITS || WORD_BITS < DAISY_DELAY) begin : g_bad_word
    $error("word too short for layout or daisy delay");
  end
  if (WIPERS < 1 || WIPERS > STORE_DEPTH || DATA_BITS < 2) begin : g_bad_wiper
    $error("wiper count or data width unsupported");
  end
  if (STORE_DEPTH > (1 << ADDR_BITS) || NV_WRITE_COUNT < 1) begin : g_bad_store
    $error("store depth or write time unsupported");
  end

  localparam int CNT_W  = $clog2(WORD_BITS + 2);
  localparam int BUSY_W = $clog2(NV_WRITE_COUNT + 1);
  localparam logic [CNT_W-1:0]  CNT_FULL = CNT_W'(WORD_BITS);
  localparam logic [CNT_W-1:0]  CNT_OVER = CNT_W'(WORD_BITS + 1);
  localparam logic [CNT_W-1:0]  CNT_ZERO = '0;
  localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(NV_WRITE_COUNT - 1);
  localparam logic [DATA_BITS-1:0] MIDSCALE =
    {1'b1, {(DATA_BITS-1){1'b0}}};
  localparam logic [DATA_BITS-1:0] ALL_ONES = '1;
  localparam logic [DATA_BITS-1:0] ONE      = DATA_BITS'(1);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [DATA_BITS-1:0] f_adjust(
    input nvpsc_adj_t             op,
    input logic [DATA_BITS-1:0]   val
  );
    logic [DATA_BITS-1:0] res;
    res = val;
    case (op)
      ADJ_INC: res = (val == ALL_ONES) ? val : val + ONE;
      ADJ_DEC: res = (val == '0) ? val : val - ONE;
      ADJ_SHL: res = (val == '0) ? ONE :
                     (val[DATA_BITS-1] ? ALL_ONES : {val[DATA_BITS-2:0], 1'b0});
      ADJ_SHR: res = {1'b0, val[DATA_BITS-1:1]};
      default: res = val;
    endcase
    return res;
  endfunction

  function automatic nvpsc_adj_t f_adj_of(input nvpsc_cmd_t cmd);
    nvpsc_adj_t op;
    op = ADJ_INC;
    case (cmd)
      CMD_SHR, CMD_SHR_ALL: op = ADJ_SHR;
      CMD_DEC, CMD_DEC_ALL: op = ADJ_DEC;
      CMD_SHL, CMD_SHL_ALL: op = ADJ_SHL;
      default:              op = ADJ_INC;
    endcase
    return op;
  endfunction

  function automatic logic f_is_adjust(input nvpsc_cmd_t cmd);
    return (cmd inside {CMD_SHR, CMD_SHR_ALL, CMD_DEC, CMD_DEC_ALL,
                        CMD_SHL, CMD_SHL_ALL, CMD_INC, CMD_INC_ALL});
  endfunction

  function automatic logic f_is_all(input nvpsc_cmd_t cmd);
    return (cmd inside {CMD_SHR_ALL, CMD_DEC_ALL, CMD_SHL_ALL, CMD_INC_ALL});
  endfunction

  // ---------------------------------------------------------------
  // system-side state declarations
  // ---------------------------------------------------------------
  nvpsc_state_t                          state_ff, nxt_state;
  logic [STORE_DEPTH-1:0][DATA_BITS-1:0] store_ff, nxt_store;
  logic [WIPERS-1:0][DATA_BITS-1:0]      wiper_ff, nxt_wiper;
  logic [BUSY_W-1:0]                     busy_cnt_ff, nxt_busy_cnt;
  logic [ADDR_BITS-1:0]                  pend_addr_ff, nxt_pend_addr;
  logic [DATA_BITS-1:0]                  pend_data_ff, nxt_pend_data;
  nvpsc_cmd_t                            held_cmd_ff, nxt_held_cmd;
  logic [ADDR_BITS-1:0]                  held_addr_ff, nxt_held_addr;
  logic                                  held_vld_ff, nxt_held_vld;
  logic [WORD_BITS-1:0]                  rb_word_ff, nxt_rb_word;
  logic                                  rb_vld_ff, nxt_rb_vld;
  logic                                  ready_ff, nxt_ready;
  logic                                  link_clr_ff, nxt_link_clr;
  logic [SYNC_STAGES:0]                  cs_sync_ff;
  logic [SYNC_STAGES:0]                  pr_sync_ff;
  logic [SYNC_STAGES-1:0]                wp_sync_ff;

  // ---------------------------------------------------------------
  // link domain: shift register and bit count
  // ---------------------------------------------------------------
  logic [WORD_BITS-1:0] lnk_shift_ff, nxt_lnk_shift;
  logic [CNT_W-1:0]     lnk_cnt_ff, nxt_lnk_cnt;
  logic                 out_bit;

  // msb first shift
  // one bit per edge
  always_comb begin
    nxt_lnk_shift = {lnk_shift_ff[WORD_BITS-2:0], sdi_in};
    nxt_lnk_cnt   = (lnk_cnt_ff == CNT_OVER) ? lnk_cnt_ff
                                             : lnk_cnt_ff + CNT_W'(1);
  end

  // rising-edge sampling serves modes 0,0 and 1,1
  always_ff @(posedge sclk_in or posedge link_clr_ff) begin
    if (link_clr_ff) begin
      lnk_shift_ff <= '0;
      lnk_cnt_ff   <= '0;
    end else if (!cs_n_in) begin
      lnk_shift_ff <= nxt_lnk_shift;
      lnk_cnt_ff   <= nxt_lnk_cnt;
    end
  end

  always_comb begin
    out_bit = lnk_shift_ff[DAISY_DELAY-1];
    if (rb_vld_ff) begin
      out_bit = (lnk_cnt_ff < CNT_FULL) ?
                rb_word_ff[WORD_BITS - 1 - int'(lnk_cnt_ff)] : 1'b1;
    end
  end

  assign sdo_out    = 1'b0;
  assign sdo_oe_out = ~cs_n_in & ~out_bit;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cs_sync_ff <= '1;
      pr_sync_ff <= '1;
      wp_sync_ff <= '1;
    end else begin
      cs_sync_ff <= {cs_sync_ff[SYNC_STAGES-1:0], cs_n_in};
      pr_sync_ff <= {pr_sync_ff[SYNC_STAGES-1:0], preset_reload_n_in};
      wp_sync_ff <= {wp_sync_ff[SYNC_STAGES-2:0], write_protect_n_in};
    end
  end

  logic cs_s, cs_rise, pr_s, pr_rise, wp_s;
  assign cs_s    = cs_sync_ff[SYNC_STAGES-1];
  assign cs_rise = cs_s & ~cs_sync_ff[SYNC_STAGES];
  assign pr_s    = pr_sync_ff[SYNC_STAGES-1];
  assign pr_rise = pr_s & ~pr_sync_ff[SYNC_STAGES];
  assign wp_s    = wp_sync_ff[SYNC_STAGES-1];

  // ---------------------------------------------------------------
  // word fields, stable while chip select is high
  // ---------------------------------------------------------------
  nvpsc_cmd_t           w_cmd;
  logic [ADDR_BITS-1:0] w_addr;
  logic [DATA_BITS-1:0] w_data;
  logic                 w_full, w_empty;

  assign w_cmd   = nvpsc_cmd_t'(lnk_shift_ff[WORD_BITS-1 -: CMD_BITS]);
  assign w_addr  = lnk_shift_ff[WORD_BITS-CMD_BITS-1 -: ADDR_BITS];
  assign w_data  = lnk_shift_ff[DATA_BITS-1:0];
  assign w_full  = (lnk_cnt_ff == CNT_FULL);
  assign w_empty = (lnk_cnt_ff == CNT_ZERO);

  // ---------------------------------------------------------------
  // command execution
  // ---------------------------------------------------------------
  nvpsc_cmd_t           x_cmd;
  logic [ADDR_BITS-1:0] x_addr;
  logic                 x_go, x_allow, x_wv;
  int                   x_idx;

  always_comb begin
    nxt_state     = state_ff;
    nxt_store     = store_ff;
    nxt_wiper     = wiper_ff;
    nxt_busy_cnt  = busy_cnt_ff;
    nxt_pend_addr = pend_addr_ff;
    nxt_pend_data = pend_data_ff;
    nxt_held_cmd  = held_cmd_ff;
    nxt_held_addr = held_addr_ff;
    nxt_held_vld  = held_vld_ff;
    nxt_rb_word   = rb_word_ff;
    nxt_rb_vld    = rb_vld_ff;
    nxt_ready     = ready_ff;
    nxt_link_clr  = 1'b0;
    x_cmd         = w_full ? w_cmd : held_cmd_ff;
    x_addr        = w_full ? w_addr : held_addr_ff;
    x_idx         = int'(x_addr);
    x_wv          = (x_idx < WIPERS);
    x_allow       = wp_s || x_cmd == CMD_STORE_TO_WIPER ||
                    x_cmd == CMD_READ_STORE;
    x_go          = 1'b0;
    case (state_ff)
      ST_BOOT: begin
        for (int i = 0; i < WIPERS; i++) begin
          nxt_wiper[i] = store_ff[i];
        end
        nxt_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (cs_rise) begin
          nxt_link_clr = 1'b1;
          nxt_rb_vld   = 1'b0;
          x_go = (w_full || (w_empty && held_vld_ff)) && x_allow;
          if (w_full) begin
            nxt_held_vld  = f_is_adjust(w_cmd) && x_allow;
            nxt_held_cmd  = w_cmd;
            nxt_held_addr = w_addr;
          end
        end
        if (x_go) begin
          case (x_cmd)
            CMD_STORE_TO_WIPER: begin
              if (x_wv) begin
                nxt_wiper[x_idx] = store_ff[x_idx];
              end
            end
            // save wiper, or any byte, into store
            CMD_SAVE_WIPER, CMD_WRITE_STORE: begin
              if (x_wv || x_cmd == CMD_WRITE_STORE) begin
                nxt_pend_addr = x_addr;
                nxt_pend_data = (x_cmd == CMD_WRITE_STORE) ? w_data
                                                           : wiper_ff[x_idx];
                nxt_busy_cnt  = BUSY_LOAD;
                nxt_ready     = 1'b0;
                nxt_state     = ST_BUSY;
              end
            end
            CMD_SHR, CMD_DEC, CMD_SHL, CMD_INC: begin
              if (x_wv) begin
                nxt_wiper[x_idx] = f_adjust(f_adj_of(x_cmd), wiper_ff[x_idx]);
              end
            end
            CMD_RESTORE_ALL: begin
              for (int i = 0; i < WIPERS; i++) begin
                nxt_wiper[i] = store_ff[i];
              end
              nxt_ready = 1'b1;
            end
            CMD_READ_STORE, CMD_READ_WIPER: begin
              nxt_rb_word = '0;
              if (x_cmd == CMD_READ_STORE) begin
                nxt_rb_word[DATA_BITS-1:0] = store_ff[x_idx];
              end else if (x_wv) begin
                nxt_rb_word[DATA_BITS-1:0] = wiper_ff[x_idx];
              end
              nxt_rb_vld = 1'b1;
              nxt_ready  = 1'b1;
            end
            CMD_WRITE_WIPER: begin
              if (x_wv) begin
                nxt_wiper[x_idx] = w_data;
              end
            end
            default: begin
              if (f_is_all(x_cmd)) begin
                for (int i = 0; i < WIPERS; i++) begin
                  nxt_wiper[i] = f_adjust(f_adj_of(x_cmd), wiper_ff[i]);
                end
              end
            end
          endcase
        end
      end
      ST_BUSY: begin
        nxt_link_clr = 1'b1;
        if (busy_cnt_ff == '0) begin
          nxt_store[pend_addr_ff] = pend_data_ff;
          nxt_ready               = 1'b1;
          nxt_state               = ST_IDLE;
        end else begin
          nxt_busy_cnt = busy_cnt_ff - BUSY_W'(1);
        end
      end
      default: begin
        nxt_state = ST_BOOT;
      end
    endcase
    if (!pr_s) begin
      for (int i = 0; i < WIPERS; i++) begin
        nxt_wiper[i] = MIDSCALE;
      end
    end else if (pr_rise) begin
      for (int i = 0; i < WIPERS; i++) begin
        nxt_wiper[i] = store_ff[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_ff     <= ST_BOOT;
      store_ff     <= {STORE_DEPTH{MIDSCALE}};
      wiper_ff     <= {WIPERS{MIDSCALE}};
      busy_cnt_ff  <= '0;
      pend_addr_ff <= '0;
      pend_data_ff <= '0;
      held_cmd_ff  <= CMD_NOP;
      held_addr_ff <= '0;
      held_vld_ff  <= 1'b0;
      rb_word_ff   <= '0;
      rb_vld_ff    <= 1'b0;
      ready_ff     <= 1'b1;
      link_clr_ff  <= 1'b1;
    end else begin
      state_ff     <= nxt_state;
      store_ff     <= nxt_store;
      wiper_ff     <= nxt_wiper;
      busy_cnt_ff  <= nxt_busy_cnt;
      pend_addr_ff <= nxt_pend_addr;
      pend_data_ff <= nxt_pend_data;
      held_cmd_ff  <= nxt_held_cmd;
      held_addr_ff <= nxt_held_addr;
      held_vld_ff  <= nxt_held_vld;
      rb_word_ff   <= nxt_rb_word;
      rb_vld_ff    <= nxt_rb_vld;
      ready_ff     <= nxt_ready;
      link_clr_ff  <= nxt_link_clr;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // ready pulls low while not ready
  assign ready_out         = 1'b0;
  assign ready_oe_out      = ~ready_ff;
  assign wiper_setting_out = wiper_ff;
  assign busy_out          = (state_ff == ST_BUSY);

endmodule // nvpsc_serial_port

// file: include/nvpsc_pkg.sv
// constants and types of the potentiometer serial command port
package nvpsc_pkg;

  // ---------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------
  localparam int CMD_BITS        = 4;
  localparam int ADDR_BITS       = 4;
  localparam int DEF_WORD_BITS   = 16;
  localparam int DEF_DATA_BITS   = 8;
  localparam int DEF_WIPERS      = 2;
  localparam int DEF_STORE_DEPTH = 16;
  localparam int DAISY_DELAY     = 16;
  localparam int SYNC_STAGES     = 2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam real CLK_PERIOD_NS  = 5.0;
  localparam real NS_PER_MS      = 1.0e6;
  localparam real NV_WRITE_MS    = 20.2;
  localparam real ROUND_HALF     = 0.5;
  localparam int  NV_WRITE_CYCLES =
    $rtoi(NV_WRITE_MS * NS_PER_MS / CLK_PERIOD_NS + ROUND_HALF);

  // ---------------------------------------------------------------
  // commands, states, adjust operations
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP            = 4'h0,
    CMD_STORE_TO_WIPER = 4'h1,
    CMD_SAVE_WIPER     = 4'h2,
    CMD_WRITE_STORE    = 4'h3,
    CMD_SHR            = 4'h4,
    CMD_SHR_ALL        = 4'h5,
    CMD_DEC            = 4'h6,
    CMD_DEC_ALL        = 4'h7,
    CMD_RESTORE_ALL    = 4'h8,
    CMD_READ_STORE     = 4'h9,
    CMD_READ_WIPER     = 4'hA,
    CMD_WRITE_WIPER    = 4'hB,
    CMD_SHL            = 4'hC,
    CMD_SHL_ALL        = 4'hD,
    CMD_INC            = 4'hE,
    CMD_INC_ALL        = 4'hF
  } nvpsc_cmd_t;

  typedef enum logic [1:0] {
    ST_BOOT = 2'h0,
    ST_IDLE = 2'h1,
    ST_BUSY = 2'h3
  } nvpsc_state_t;

  typedef enum logic [1:0] {
    ADJ_INC = 2'h0,
    ADJ_DEC = 2'h1,
    ADJ_SHL = 2'h2,
    ADJ_SHR = 2'h3
  } nvpsc_adj_t;

endpackage

// file: dv/nvpsc_chk.sv
// assertion checker of the potentiometer serial command port
`timescale 1ns/1ps
module nvpsc_chk
  import nvpsc_pkg::*;
#(
  parameter int WIPERS         = DEF_WIPERS,
  parameter int DATA_BITS      = DEF_DATA_BITS,
  parameter int NV_WRITE_COUNT = NV_WRITE_CYCLES
) (
  // clock and reset
  input wire logic                        clk_in,
  input wire logic                        reset_n_in,
  // link and controls
  input wire logic                        sclk_in,
  input wire logic                        cs_n_in,
  input wire logic                        sdi_in,
  input wire logic                        preset_reload_n_in,
  input wire logic                        write_protect_n_in,
  // outputs
  input wire logic                        sdo_out,
  input wire logic                        sdo_oe_out,
  input wire logic                        ready_out,
  input wire logic                        ready_oe_out,
  input wire logic [WIPERS-1:0][DATA_BITS-1:0] wiper_setting_out,
  input wire logic                        busy_out
);
  localparam logic [DATA_BITS-1:0] MID = {1'b1, {(DATA_BITS-1){1'b0}}};
  logic [31:0] busy_cnt_ff;
  logic [31:0] nxt_busy_cnt;

  // -------------------------------------------------------------
  // lock length counter and properties
  // -------------------------------------------------------------
  always_comb begin
    nxt_busy_cnt = busy_out ? busy_cnt_ff + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_in) begin
    busy_cnt_ff <= reset_n_in ? nxt_busy_cnt : 32'h0;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sdo_idle_a: assert property (cs_n_in |-> !sdo_oe_out)
    else $error("serial output pulls low while deselected");
  od_low_a: assert property (!sdo_out && !ready_out)
    else $error("open drain value not low");
  busy_len_a: assert property ($fell(busy_out) |->
    busy_cnt_ff >= NV_WRITE_COUNT && busy_cnt_ff <= NV_WRITE_COUNT + 1)
    else $error("store lock length wrong");
  busy_rdy_a: assert property (busy_out |-> ready_oe_out)
    else $error("ready high during store lock");
  rdy_rise_a: assert property ($rose(ready_oe_out) |-> busy_out)
    else $error("ready dropped without a store write");
  rdy_done_a: assert property ($fell(busy_out) |-> !ready_oe_out)
    else $error("ready not back after store write");
  wip_src_a: assert property (!$stable(wiper_setting_out) |->
    $past(cs_n_in, 2) || !$past(preset_reload_n_in, 3) ||
    !$past(preset_reload_n_in, 4) || !$past(preset_reload_n_in, 5))
    else $error("wiper changed without strobe or preset");
  preset_mid_a: assert property ((!preset_reload_n_in) [*5] |->
    wiper_setting_out == {WIPERS{MID}})
    else $error("wiper not midscale under preset");
  busy_hold_a: assert property (busy_out [*2] |->
    $stable(wiper_setting_out))
    else $error("wiper changed during store lock");
  wp_save_a: assert property ((!write_protect_n_in) [*6] |->
    !$rose(busy_out))
    else $error("store write under write protect");

  cover property ($fell(busy_out));
  cover property ((!preset_reload_n_in) [*5]);
  cover property ((!write_protect_n_in) [*6] ##1 !cs_n_in);
endmodule // nvpsc_chk

bind nvpsc_serial_port nvpsc_chk #(
  .WIPERS(WIPERS), .DATA_BITS(DATA_BITS), .NV_WRITE_COUNT(NV_WRITE_COUNT)
) chk_i (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .sclk_in(sclk_in),
  .cs_n_in(cs_n_in), .sdi_in(sdi_in), .sdo_out(sdo_out),
  .sdo_oe_out(sdo_oe_out), .ready_out(ready_out),
  .ready_oe_out(ready_oe_out), .preset_reload_n_in(preset_reload_n_in),
  .write_protect_n_in(write_protect_n_in),
  .wiper_setting_out(wiper_setting_out), .busy_out(busy_out)
);

// file: dv/nvpsc_master.sv
// serial master model driving the potentiometer link
`timescale 1ns/1ps
module nvpsc_master (
  // link to the device
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      sdi_out,
  input  wire logic sdo_in
);
  // -------------------------------------------------------------
  // framed transfer, clock still between frames
  // -------------------------------------------------------------
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  task automatic xfer(input logic [31:0] w, input int n,
                      output logic [31:0] rx);
    rx = 32'h0;
    #3;
    cs_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_out = w[i];
      #80;
      rx = {rx[30:0], sdo_in};
      sclk_out = 1'b1;
      #80;
      sclk_out = 1'b0;
    end
    #80;
    cs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #200;
  endtask
endmodule // nvpsc_master

// file: dv/nvpsc_tb.sv
// self-checking testbench of the potentiometer serial command port
`timescale 1ns/1ps
module tb;
  import nvpsc_pkg::*;
  localparam int NVW = 1000;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic preset_n = 1'b1;
  logic wp_n = 1'b1;
  logic sclk, cs_n, sdi, sdo, sdo_oe, rdy, rdy_oe, busy;
  logic [1:0][7:0] wip;
  logic [7:0] mw [2];
  logic [7:0] ms [16];
  logic [3:0] ops [8] = '{4'hE, 4'hF, 4'hC, 4'hD, 4'h4, 4'h5, 4'h6, 4'h7};
  logic [31:0] rx;
  logic [7:0] d;
  int error_cnt = 0;
  int check_count = 0;
  int seed = 32'h3F74;
  wire sdo_line = sdo_oe ? sdo : 1'b1;
  wire rdy_line = rdy_oe ? rdy : 1'b1;

  always #2.5 clk_in = ~clk_in;

  nvpsc_serial_port #(.NV_WRITE_COUNT(NVW)) dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .ready_out(rdy), .ready_oe_out(rdy_oe),
    .preset_reload_n_in(preset_n), .write_protect_n_in(wp_n),
    .wiper_setting_out(wip), .busy_out(busy));
  nvpsc_master mst (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
    .sdo_in(sdo_line));

  // -------------------------------------------------------------
  // helpers and reference model
  // -------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chkw();
    for (int i = 0; i < 2; i++) chk(wip[i], mw[i]);
  endtask
  task automatic send(input logic [3:0] c, input logic [3:0] a,
                      input logic [7:0] v);
    mst.xfer({16'h0, c, a, v}, 16, rx);
  endtask
  task automatic read(input logic [3:0] c, input logic [3:0] a);
    send(c, a, 8'h0);
    mst.xfer(32'h0, 16, rx);
  endtask
  task automatic wait_idle();
    for (int k = 0; k < NVW + 200 && busy !== 1'b0; k++) @(posedge clk_in);
    chk(busy, 1'b0);
    chk(rdy_line, 1'b1);
  endtask
  function automatic logic [7:0] adj(input logic [3:0] c,
                                     input logic [7:0] v);
    if (c[1])
      return c[3] ? (v == 8'hFF ? v : v + 8'h1) : (v == 8'h0 ? v : v - 8'h1);
    return c[3] ? (v == 8'h0 ? 8'h1 : (v[7] ? 8'hFF : v << 1)) : v >> 1;
  endfunction
  task automatic apply(input logic [3:0] c);
    for (int i = 0; i < 2; i++) if (c[0] || i == 1) mw[i] = adj(c, mw[i]);
  endtask
  task automatic end_of_test();
    $display("checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    foreach (mw[i]) mw[i] = 8'h80;
    foreach (ms[i]) ms[i] = 8'h80;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    chkw();
    for (int a = 0; a < 3; a++) begin
      d = $random(seed);
      send(4'hB, a[3:0], d);
      if (a < 2) mw[a] = d;
      chkw();
    end
    send(4'hB, 4'h0, 8'hFE);
    send(4'hB, 4'h1, 8'h01);
    mw[0] = 8'hFE;
    mw[1] = 8'h01;
    foreach (ops[j]) begin
      send(ops[j], 4'h1, 8'h0);
      apply(ops[j]);
      chkw();
      mst.xfer(32'h0, 0, rx);
      apply(ops[j]);
      chkw();
    end
    mst.xfer(32'h3055, 15, rx);
    chkw();
    mst.xfer(32'hB011C0DE, 32, rx);
    chk(rx[31:16], 16'h0);
    chk(rx[15:0], 16'hB011);
    chkw();
    send(4'h2, 4'h0, 8'h0);
    chk(busy, 1'b1);
    chk(rdy_line, 1'b0);
    send(4'hB, 4'h0, 8'h11);
    wait_idle();
    ms[0] = mw[0];
    chkw();
    read(4'h9, 4'h0);
    chk(rx[15:0], {8'h0, ms[0]});
    read(4'hA, 4'h1);
    chk(rx[15:0], {8'h0, mw[1]});
    send(4'hB, 4'h0, 8'h77);
    send(4'h1, 4'h0, 8'h0);
    mw[0] = ms[0];
    chkw();
    send(4'hB, 4'h1, 8'h55);
    send(4'h8, 4'h0, 8'h0);
    mw[1] = ms[1];
    chkw();
    d = $random(seed);
    send(4'h3, 4'h5, d);
    chk(busy, 1'b1);
    wait_idle();
    read(4'h9, 4'h5);
    chk(rx[15:0], {8'h0, d});
    send(4'hB, 4'h0, 8'h99);
    mw[0] = 8'h99;
    @(posedge clk_in);
    wp_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    send(4'hB, 4'h0, 8'h12);
    send(4'h2, 4'h0, 8'h0);
    chk(busy, 1'b0);
    chkw();
    send(4'h1, 4'h0, 8'h0);
    mw[0] = ms[0];
    chkw();
    wp_n <= 1'b1;
    send(4'hB, 4'h1, 8'h03);
    mw[1] = 8'h03;
    chkw();
    @(posedge clk_in);
    preset_n <= 1'b0;
    repeat (10) @(posedge clk_in);
    for (int i = 0; i < 2; i++) chk(wip[i], 8'h80);
    preset_n <= 1'b1;
    foreach (mw[i]) mw[i] = ms[i];
    repeat (10) @(posedge clk_in);
    chkw();
    send(4'h0, 4'h0, 8'h0);
    chkw();
    end_of_test();
  end
endmodule // tb
